// ---- rtl/ssvta_core.sv ----
// register bank and indirect access engine for static, reserved and VLAN tables
`timescale 1ns/1ps
module ssvta_core
  import ssvta_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [47:0] da_mac_i,
  input wire logic [6:0] da_fid_i,
  input wire logic [5:0] rsvd_lsb_i,
  input wire logic vl_req_i,
  input wire logic [11:0] vl_vid_i,
  output ssvta_static_rsp_type static_rsp_o,
  output logic [6:0] rsvd_mask_o,
  output ssvta_vlan_rsp_type vlan_rsp_o,
  output logic vlan_mode_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    ssvta_static_type [SSVTA_STATIC_ENTRIES-1:0] stat;
    logic [SSVTA_RSVD_GROUPS-1:0][6:0] rsvd;
    logic bypass;
    logic grpm;
    logic [6:0] mask;
    logic [6:0] filter_group_identifier;
    logic [15:0] mac_hi;
    logic [31:0] mac_lo;
    logic [5:0] idx;
    logic go;
    logic tsel;
    logic act;
    ssvta_vlan_type vw;
    logic [11:0] vidx;
    logic vgo;
    logic vact;
    logic vmode;
    ssvta_op_type op;
    ssvta_static_rsp_type srsp;
    logic [6:0] rmask;
    logic vreq;
  } ssvta_state_type;

  ssvta_state_type s_q, s_d;

  // VLAN storage is too large for the state record, so it lives in its own array
  ssvta_vlan_type vlan_mem [SSVTA_VLAN_ENTRIES]; // RQ12
  ssvta_vlan_type cpu_rd_q;
  ssvta_vlan_type lk_rd_q;
  logic mem_we;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // fixed grouping of the 48 reserved addresses; indices 48..63 belong to none
  function automatic logic [3:0] rsvd_group(input logic [5:0] a);
    logic [3:0] g;
    g = 4'h8;
    if (a == 6'h00) begin
      g = 4'h0;
    end else if (a == 6'h01) begin
      g = 4'h1;
    end else if (a == 6'h03) begin
      g = 4'h2;
    end else if (a == 6'h02 || (a >= 6'h04 && a <= 6'h0f)) begin
      g = 4'h3;
    end else if (a == 6'h10) begin
      g = 4'h4;
    end else if (a == 6'h20) begin
      g = 4'h5;
    end else if (a == 6'h21) begin
      g = 4'h6;
    end else if (a < 6'h30) begin
      g = 4'h7;
    end
    return g; // RQ6
  endfunction

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  logic [31:0] rd_word;
  logic [31:0] cur_word;
  logic mapped;

  always_comb begin
    mapped = 1'b1;
    unique case (wb_adr_i & 16'hfffc)
      SSVTA_ADR_FWD: rd_word = {s_q.bypass, s_q.grpm, 23'h00_0000, s_q.mask};
      SSVTA_ADR_GRP: rd_word = {9'h000, s_q.filter_group_identifier, s_q.mac_hi}; // RQ4
      SSVTA_ADR_MACLO: rd_word = s_q.mac_lo;
      SSVTA_ADR_CTL: rd_word = {22'h00_0000, s_q.act, s_q.tsel, s_q.go, 1'b0, s_q.idx};
      SSVTA_ADR_VL0: rd_word = {s_q.vw.valid, s_q.vw.fwd_opt, s_q.vw.prio, s_q.vw.msti,
                                17'h0_0000, s_q.vw.filter_group_identifier};
      SSVTA_ADR_VL1: rd_word = {25'h000_0000, s_q.vw.untag};
      SSVTA_ADR_VL2: rd_word = {25'h000_0000, s_q.vw.member};
      SSVTA_ADR_VIDX: rd_word = {20'h0_0000, s_q.vidx};
      SSVTA_ADR_VCTL: rd_word = {24'h00_0000, s_q.vgo, 6'h00, s_q.vact};
      SSVTA_ADR_CFG: rd_word = {31'h0000_0000, s_q.vmode};
      default: begin
        rd_word = SSVTA_WORD_RST;
        mapped = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic wr_en;
  logic busy;
  logic [31:0] w;
  logic [3:0] grp;
  logic [3:0] sidx;

  always_comb begin
    s_d = s_q;
    w = SSVTA_WORD_RST;
    busy = (s_q.op != SSVTA_OP_IDLE) || s_q.go || s_q.vgo;
    grp = rsvd_group(s_q.idx);
    sidx = s_q.idx[3:0]; // RQ23

    // wishbone classic: one wait state, ack dropped the cycle after it was given
    s_d.ack = wb_cyc_i && wb_stb_i && !s_q.ack;
    wr_en = wb_cyc_i && wb_stb_i && !s_q.ack && wb_we_i && mapped;
    cur_word = rd_word;
    if (s_d.ack) begin
      s_d.dat = wb_we_i ? SSVTA_WORD_RST : rd_word;
    end

    // table-facing registers are frozen while an access runs
    if (wr_en) begin
      w = merge(cur_word, wb_dat_i, wb_sel_i);
      unique case (wb_adr_i & 16'hfffc)
        SSVTA_ADR_FWD: begin
          if (!busy) begin
            s_d.bypass = w[SSVTA_FWD_BYPASS_BIT];
            s_d.grpm = w[SSVTA_FWD_GRPM_BIT];
            s_d.mask = w[6:0]; // RQ3
          end
        end
        SSVTA_ADR_GRP: begin
          if (!busy) begin
            s_d.filter_group_identifier = w[SSVTA_GRP_FID_LSB +: 7];
            s_d.mac_hi = w[15:0];
          end
        end
        SSVTA_ADR_MACLO: begin
          if (!busy) begin
            s_d.mac_lo = w;
          end
        end
        SSVTA_ADR_CTL: begin
          if (!busy) begin
            s_d.idx = w[5:0];
            s_d.tsel = w[SSVTA_CTL_TSEL_BIT];
            s_d.act = w[SSVTA_CTL_ACT_BIT];
            s_d.go = w[SSVTA_CTL_GO_BIT];
          end
        end
        SSVTA_ADR_VL0: begin
          if (!busy) begin
            s_d.vw.valid = w[31];
            s_d.vw.fwd_opt = w[30];
            s_d.vw.prio = w[29:27];
            s_d.vw.msti = w[26:24];
            s_d.vw.filter_group_identifier = w[6:0];
          end
        end
        SSVTA_ADR_VL1: begin
          if (!busy) begin
            s_d.vw.untag = w[6:0];
          end
        end
        SSVTA_ADR_VL2: begin
          if (!busy) begin
            s_d.vw.member = w[6:0];
          end
        end
        SSVTA_ADR_VIDX: begin
          if (!busy) begin
            s_d.vidx = w[11:0]; // RQ21
          end
        end
        SSVTA_ADR_VCTL: begin
          if (!busy) begin
            s_d.vact = w[SSVTA_VCTL_ACT_BIT];
            s_d.vgo = w[SSVTA_VCTL_GO_BIT]; // RQ22
          end
        end
        SSVTA_ADR_CFG: s_d.vmode = w[0];
        default: s_d.vmode = s_q.vmode;
      endcase
    end

    // ----------------------------------------------------------------
    // access engine
    // ----------------------------------------------------------------
    unique case (s_q.op)
      SSVTA_OP_IDLE: begin
        if (s_q.go) begin
          s_d.op = SSVTA_OP_STATIC;
        end else if (s_q.vgo) begin
          s_d.op = SSVTA_OP_VLAN_ISSUE; // RQ14
        end
      end
      SSVTA_OP_STATIC: begin
        if (s_q.tsel) begin // RQ10
          if (grp < 4'h8) begin // RQ5
            if (s_q.act) begin
              s_d.mask = s_q.rsvd[grp[2:0]]; // RQ7
            end else begin
              s_d.rsvd[grp[2:0]] = s_q.mask; // RQ6
            end
          end else if (s_q.act) begin
            s_d.mask = SSVTA_MASK_RST;
          end
        end else if (s_q.act) begin
          s_d.bypass = s_q.stat[sidx].bypass;
          s_d.grpm = s_q.stat[sidx].grpm;
          s_d.mask = s_q.stat[sidx].mask;
          s_d.filter_group_identifier = s_q.stat[sidx].filter_group_identifier;
          s_d.mac_hi = s_q.stat[sidx].mac[47:32];
          s_d.mac_lo = s_q.stat[sidx].mac[31:0];
        end else begin
          s_d.stat[sidx].used = 1'b1;
          s_d.stat[sidx].bypass = s_q.bypass;
          s_d.stat[sidx].grpm = s_q.grpm;
          s_d.stat[sidx].mask = s_q.mask;
          s_d.stat[sidx].filter_group_identifier = s_q.filter_group_identifier;
          s_d.stat[sidx].mac = {s_q.mac_hi, s_q.mac_lo}; // RQ4
        end
        s_d.go = 1'b0; // RQ11
        s_d.op = SSVTA_OP_IDLE;
      end
      SSVTA_OP_VLAN_ISSUE: begin
        if (s_q.vact) begin
          s_d.op = SSVTA_OP_VLAN_CAPT;
        end else begin
          s_d.vgo = 1'b0; // RQ22
          s_d.op = SSVTA_OP_IDLE;
        end
      end
      SSVTA_OP_VLAN_CAPT: begin
        s_d.vw = cpu_rd_q;
        s_d.vgo = 1'b0; // RQ22
        s_d.op = SSVTA_OP_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // lookups
    // ----------------------------------------------------------------
    // lowest index wins when several static entries match
    s_d.srsp = '0;
    for (int e = SSVTA_STATIC_ENTRIES - 1; e >= 0; e--) begin
      if (s_q.stat[e].used && s_q.stat[e].mac == da_mac_i &&
          (!(s_q.stat[e].grpm && da_mac_i[SSVTA_MCAST_BIT]) ||
           s_q.stat[e].filter_group_identifier == da_fid_i)) begin // RQ2
        s_d.srsp.hit = 1'b1;
        s_d.srsp.bypass = s_q.stat[e].bypass; // RQ1
        s_d.srsp.mask = s_q.stat[e].mask; // RQ3
      end
    end
    grp = rsvd_group(rsvd_lsb_i);
    s_d.rmask = (grp < 4'h8) ? s_q.rsvd[grp[2:0]] : SSVTA_MASK_RST; // RQ5
    s_d.vreq = vl_req_i && s_q.vmode; // RQ12
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign mem_we = (s_q.op == SSVTA_OP_VLAN_ISSUE) && !s_q.vact;

  // two read ports: one for software, one for the packet path
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      vlan_mem[s_q.vidx] <= s_q.vw; // RQ15 RQ16 RQ17 RQ18 RQ19 RQ20
    end
    cpu_rd_q <= vlan_mem[s_q.vidx];
    lk_rd_q <= vlan_mem[vl_vid_i]; // RQ21
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.dat;
  assign static_rsp_o = s_q.srsp;
  assign rsvd_mask_o = s_q.rmask;
  assign vlan_mode_o = s_q.vmode;
  assign vlan_rsp_o.rsp_valid = s_q.vreq;
  // entry fields are meaningful only with rsp_valid; valid flag tells downstream
  // whether the id is configured
  assign vlan_rsp_o.entry = s_q.vreq ? lk_rd_q : '0; // RQ15

endmodule // ssvta_core

// ---- rtl/ssvta_pkg.sv ----
// constants, field layouts and carrier types of the table access block
// How it works
// RQ1: forward word bit 31 bypasses port state
// RQ2: bit 30 adds group id to multicast matching
// RQ3: bits 6:0 egress mask, bit 0 port 1
// RQ4: word three group id/mac high, word four mac low
// RQ5: 48 reserved addresses indexed by low six bits
// RQ6: write to one address updates its whole group
// RQ7: reserved table shares control and forward word
// RQ8: software loads mask, then starts write
// RQ9: software starts read, then reads forward word
// RQ10: table chooser one selects reserved table, 6-bit index
// RQ11: device clears go bit when access finishes
// RQ12: 4096 VLAN entries consulted in VLAN mode
// RQ13: software fills VLAN table before enabling mode
// RQ14: VLAN table reached one entry at a time
// RQ15: VLAN entry valid only when flag is one
// RQ16: forward choice one uses entry membership mask
// RQ17: entry carries 3-bit priority and instance index
// RQ18: entry carries 7-bit group id for hashing
// RQ19: entry carries 7-bit egress untag mask
// RQ20: entry carries 7-bit membership, lsb port 1
// RQ21: VLAN index is 12 bits, equals VLAN id
// RQ22: VLAN access starts on bit 7, self clears
// RQ23: static table 16 entries, chooser 0, 4-bit index
// RQ24: software polls go bit clear before next step
package ssvta_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] SSVTA_ADR_FWD = 16'h0424;
  localparam logic [15:0] SSVTA_ADR_GRP = 16'h0428;
  localparam logic [15:0] SSVTA_ADR_MACLO = 16'h042c;
  localparam logic [15:0] SSVTA_ADR_CTL = 16'h0430;
  localparam logic [15:0] SSVTA_ADR_VL0 = 16'h0440;
  localparam logic [15:0] SSVTA_ADR_VL1 = 16'h0444;
  localparam logic [15:0] SSVTA_ADR_VL2 = 16'h0448;
  localparam logic [15:0] SSVTA_ADR_VIDX = 16'h044c;
  localparam logic [15:0] SSVTA_ADR_VCTL = 16'h0450;
  localparam logic [15:0] SSVTA_ADR_CFG = 16'h0454;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SSVTA_FWD_BYPASS_BIT = 31;
  localparam int SSVTA_FWD_GRPM_BIT = 30;
  localparam int SSVTA_GRP_FID_LSB = 16;
  localparam int SSVTA_CTL_GO_BIT = 7;
  localparam int SSVTA_CTL_TSEL_BIT = 8;
  localparam int SSVTA_CTL_ACT_BIT = 9;
  localparam int SSVTA_VCTL_GO_BIT = 7;
  localparam int SSVTA_VCTL_ACT_BIT = 0;
  localparam int SSVTA_MCAST_BIT = 40;

  // ----------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------
  localparam int SSVTA_PORTS = 7;
  localparam int SSVTA_STATIC_ENTRIES = 16;
  localparam int SSVTA_RSVD_ADDRS = 48;
  localparam int SSVTA_RSVD_GROUPS = 8;
  localparam int SSVTA_VLAN_ENTRIES = 4096;
  localparam logic [31:0] SSVTA_WORD_RST = 32'h0000_0000;
  localparam logic [6:0] SSVTA_MASK_RST = 7'h00;

  typedef enum logic [1:0] {
    SSVTA_OP_IDLE,
    SSVTA_OP_STATIC,
    SSVTA_OP_VLAN_ISSUE,
    SSVTA_OP_VLAN_CAPT
  } ssvta_op_type;

  typedef struct packed {
    logic used;
    logic bypass;
    logic grpm;
    logic [6:0] mask;
    logic [6:0] filter_group_identifier;
    logic [47:0] mac;
  } ssvta_static_type;

  typedef struct packed {
    logic valid;
    logic fwd_opt;
    logic [2:0] prio;
    logic [2:0] msti;
    logic [6:0] filter_group_identifier;
    logic [6:0] untag;
    logic [6:0] member;
  } ssvta_vlan_type;

  typedef struct packed {
    logic hit;
    logic bypass;
    logic [6:0] mask;
  } ssvta_static_rsp_type;

  typedef struct packed {
    logic rsp_valid;
    ssvta_vlan_type entry;
  } ssvta_vlan_rsp_type;

endpackage

// ---- tb/ssvta_core_properties.sv ----
// port assertions and covers for the table access block
`timescale 1ns/1ps
module ssvta_core_properties
  import ssvta_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [47:0] da_mac_i,
  input wire logic [6:0] da_fid_i,
  input wire logic [5:0] rsvd_lsb_i,
  input wire logic vl_req_i,
  input wire logic [11:0] vl_vid_i,
  input ssvta_static_rsp_type static_rsp_o,
  input wire logic [6:0] rsvd_mask_o,
  input ssvta_vlan_rsp_type vlan_rsp_o,
  input wire logic vlan_mode_o
);
  // ----
  // bus and lookup relations
  // ----
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  AST_ACK_ONE_WAIT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_UNMAPPED_ZERO: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 16'h0420)
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  AST_FWD_RSV_ZERO: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == SSVTA_ADR_FWD)
    |-> wb_dat_o[29:7] == 23'h0) else $error("forward word reserved bits set");
  AST_GRP_RSV_ZERO: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == SSVTA_ADR_GRP)
    |-> wb_dat_o[31:23] == 9'h0) else $error("group word reserved bits set");
  AST_RSVD_HIGH_ZERO: assert property ($past(rsvd_lsb_i) >= 6'h30 |-> rsvd_mask_o == 7'h00)
    else $error("mask for index past 47");
  AST_VLAN_VALID: assert property (vlan_rsp_o.rsp_valid == $past(vl_req_i && vlan_mode_o))
    else $error("vlan response timing wrong");
  AST_VLAN_IDLE_ZERO: assert property (!vlan_rsp_o.rsp_valid |-> vlan_rsp_o.entry == '0)
    else $error("vlan entry shown without response");

  COV_GO: cover property (wb_ack_o && $past(wb_we_i && wb_adr_i == SSVTA_ADR_CTL));
  COV_VLAN: cover property (vlan_rsp_o.rsp_valid);
  COV_RSVD: cover property (rsvd_mask_o != 7'h00);
endmodule // ssvta_core_properties

bind ssvta_core ssvta_core_properties u_ssvta_core_properties (.clk_sys(clk_sys), .nrst(nrst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .da_mac_i(da_mac_i), .da_fid_i(da_fid_i), .rsvd_lsb_i(rsvd_lsb_i), .vl_req_i(vl_req_i),
  .vl_vid_i(vl_vid_i), .static_rsp_o(static_rsp_o), .rsvd_mask_o(rsvd_mask_o),
  .vlan_rsp_o(vlan_rsp_o), .vlan_mode_o(vlan_mode_o));

// ---- tb/ssvta_core_tb_top.sv ----
// self-checking bench for the table access block
`timescale 1ns/1ps
module ssvta_core_tb_top
  import ssvta_pkg::*;
;
  typedef struct packed {
    logic [15:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } ssvta_tb_row_type;

  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [15:0] wb_adr_i = 16'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [47:0] da_mac_i = 48'h0;
  logic [6:0] da_fid_i = 7'h0;
  logic [5:0] rsvd_lsb_i = 6'h0;
  logic vl_req_i = 1'b0;
  logic [11:0] vl_vid_i = 12'habc;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  ssvta_static_rsp_type static_rsp_o;
  logic [6:0] rsvd_mask_o;
  ssvta_vlan_rsp_type vlan_rsp_o;
  logic vlan_mode_o;
  int errors = 0;
  int samples_checked = 0;
  ssvta_tb_row_type rows [5] = '{
    '{16'h0424, 32'hffff_ffff, 32'hc000_007f},
    '{16'h0428, 32'hffff_ffff, 32'h007f_ffff},
    '{16'h042c, 32'ha5a5_5a5a, 32'ha5a5_5a5a},
    '{16'h0420, 32'hffff_ffff, 32'h0000_0000},
    '{16'h044c, 32'h0000_ffff, 32'h0000_0fff}};

  always #10 clk_sys = ~clk_sys;

  ssvta_core u_ssvta_core (.clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .da_mac_i(da_mac_i),
    .da_fid_i(da_fid_i), .rsvd_lsb_i(rsvd_lsb_i), .vl_req_i(vl_req_i), .vl_vid_i(vl_vid_i),
    .static_rsp_o(static_rsp_o), .rsvd_mask_o(rsvd_mask_o), .vlan_rsp_o(vlan_rsp_o),
    .vlan_mode_o(vlan_mode_o));

  // ----
  // shared tasks
  // ----
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // master holds the request until a rising edge samples ack high; ack is looked at
  // mid-cycle, away from the edge that launches it, to stay clear of the update race
  task wb(input logic we, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 100);
    if (n >= 100) errors++;
    q = wb_dat_o;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task rd_chk(input string nm, input logic [15:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask

  task poll(input logic [15:0] a);
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      wb(1'b0, a, 32'h0, q);
      n++;
    end while (q[7] !== 1'b0 && n < 20);
    chk("go_done", 32'h0, {31'h0, q[7]});
  endtask

  // lookup inputs held; sampled after their registered answer settles
  task look(input logic [47:0] m, input logic [6:0] f, input logic [5:0] l, input logic r);
    @(posedge clk_sys);
    da_mac_i <= m;
    da_fid_i <= f;
    rsvd_lsb_i <= l;
    vl_req_i <= r;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd_chk("row", rows[i].a, rows[i].e);
    end
    wr(SSVTA_ADR_FWD, 32'h8000_0055);
    wr(SSVTA_ADR_GRP, 32'h0012_1234);
    wr(SSVTA_ADR_MACLO, 32'h89ab_cdef);
    wr(SSVTA_ADR_CTL, 32'h0000_0083);
    poll(SSVTA_ADR_CTL);
    look(48'h1234_89ab_cdef, 7'h00, 6'h00, 1'b0);
    chk("static_hit", 32'h1d5, 32'(static_rsp_o));
    look(48'h1234_89ab_cdee, 7'h00, 6'h00, 1'b0);
    chk("static_miss", 32'h0, {31'h0, static_rsp_o.hit});
    wr(SSVTA_ADR_FWD, 32'h4000_0011);
    wr(SSVTA_ADR_GRP, 32'h0005_0100);
    wr(SSVTA_ADR_MACLO, 32'h0000_0001);
    wr(SSVTA_ADR_CTL, 32'h0000_0084);
    poll(SSVTA_ADR_CTL);
    look(48'h0100_0000_0001, 7'h06, 6'h00, 1'b0);
    chk("fid_miss", 32'h0, {31'h0, static_rsp_o.hit});
    look(48'h0100_0000_0001, 7'h05, 6'h00, 1'b0);
    chk("fid_hit", 32'h111, 32'(static_rsp_o));
    wr(SSVTA_ADR_MACLO, 32'h0);
    wr(SSVTA_ADR_CTL, 32'h0000_0283);
    poll(SSVTA_ADR_CTL);
    rd_chk("st_fwd", SSVTA_ADR_FWD, 32'h8000_0055);
    rd_chk("st_grp", SSVTA_ADR_GRP, 32'h0012_1234);
    rd_chk("st_mac", SSVTA_ADR_MACLO, 32'h89ab_cdef);
    wr(SSVTA_ADR_FWD, 32'h0000_002a);
    wr(SSVTA_ADR_CTL, 32'h0000_0191);
    poll(SSVTA_ADR_CTL);
    wr(SSVTA_ADR_FWD, 32'h0);
    wr(SSVTA_ADR_CTL, 32'h0000_03af);
    poll(SSVTA_ADR_CTL);
    rd_chk("rsvd_group", SSVTA_ADR_FWD, 32'h0000_002a);
    look(48'h0, 7'h00, 6'h1f, 1'b0);
    chk("rsvd_mask", 32'h2a, 32'(rsvd_mask_o));
    look(48'h0, 7'h00, 6'h30, 1'b0);
    chk("rsvd_high", 32'h0, 32'(rsvd_mask_o));
    look(48'h0, 7'h00, 6'h1f, 1'b0);
    look(48'h0, 7'h00, 6'h10, 1'b0);
    chk("rsvd_other", 32'h0, 32'(rsvd_mask_o));
    wr(SSVTA_ADR_VL0, 32'hcb00_0033);
    wr(SSVTA_ADR_VL1, 32'h0000_0015);
    wr(SSVTA_ADR_VL2, 32'h0000_006a);
    wr(SSVTA_ADR_VIDX, 32'h0000_0abc);
    wr(SSVTA_ADR_VCTL, 32'h0000_0080);
    poll(SSVTA_ADR_VCTL);
    wr(SSVTA_ADR_VL0, 32'h0);
    wr(SSVTA_ADR_VL1, 32'h0);
    wr(SSVTA_ADR_VL2, 32'h0);
    wr(SSVTA_ADR_VCTL, 32'h0000_0081);
    poll(SSVTA_ADR_VCTL);
    rd_chk("vl0", SSVTA_ADR_VL0, 32'hcb00_0033);
    rd_chk("vl1", SSVTA_ADR_VL1, 32'h0000_0015);
    rd_chk("vl2", SSVTA_ADR_VL2, 32'h0000_006a);
    wr(SSVTA_ADR_CFG, 32'h1);
    look(48'h0, 7'h00, 6'h00, 1'b1);
    chk("vlan_rsp", 32'({3'h7, 3'd1, 3'd3, 7'h33, 7'h15, 7'h6a}), 32'(vlan_rsp_o));
    wr(SSVTA_ADR_CFG, 32'h0);
    look(48'h0, 7'h00, 6'h00, 1'b1);
    chk("vlan_off", 32'h0, 32'(vlan_rsp_o));
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    rd_chk("rst_mac", SSVTA_ADR_MACLO, 32'h0);
    rd_chk("rst_ctl", SSVTA_ADR_CTL, 32'h0);
    tally_and_finish;
  end

  // the sequence needs well under a thousand cycles
  initial begin
    #200_000;
    errors++;
    tally_and_finish;
  end
endmodule // ssvta_core_tb_top
